// ---- core/bus_arb_pkg.sv ----
// Constants and types for the shared bus arbiter of one processor
// Operation
// - Mastership moves only in a transition cycle: master drops, slave requests.
// - Master keeping its request asserted keeps the bus.
// - Master drops with no other request: no bus cycles lost.
// - Highest current priority requester becomes master on the following cycle.
// - Every processor watches all request lines and tracks the owner.
// - A change of master costs exactly one overhead cycle.
// - Rotating: previous master goes lowest, others rotate upward.
// - Bus lock keeps ownership for read-modify-write sequences.
// - Optional limit on consecutive master cycles, either scheme.
// - Core priority access lets slave core requests preempt DMA.
// - Master broadcast write accepted by all others in same cycle.
// - Eight message registers readable and writable by the bus master.
// - Write to vector interrupt register raises immediate interrupt to that address.
// - Upper address bits decode to bank select strobes.
// - Programmable wait states plus acknowledge input stretch accesses.
// - Host boot mode: idle, request deasserted, until loaded.
// - No-boot mode fetches from external address 0x0040_0004.
// - First processor boot mode separate; other five share one setting.
// - First processor may load others through their DMA buffer zero.
// - Wire-ORed boot selects: boot in priority order, last signals go.
// - Drive only own request line, watch the others; six lines.
package bus_arb_pkg;
	localparam int NUM_ID = 6;
	localparam int ID_W = 3;
	localparam int PRIO_W = 3;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int NUM_MSG = 8;
	localparam int MSG_W = 3;
	localparam int WAIT_W = 4;
	localparam int LIMIT_W = 8;
	localparam logic [ADDR_W-1:0] NO_BOOT_ADDR = 32'h0040_0004;
	localparam logic [ADDR_W-1:0] EXT_BASE = 32'h0040_0000;
	localparam int BANK_LSB = 26;
	localparam int BANK_W = 2;
	localparam logic [ID_W-1:0] FIRST_ID = 3'h1;
	localparam logic [ID_W-1:0] NO_ID = 3'h0;
	localparam int ID_BASE = 1;
	localparam int COUNT_STEP = 1;
	localparam logic [ADDR_W-1:0] BOOT_LOAD_ADDR = 32'h0000_0000;
	localparam logic [7:0] CLK_MHZ = 8'h14;

	typedef enum logic [1:0] {
		BOOT_HOST,
		BOOT_EPROM,
		BOOT_LINK,
		BOOT_NONE
	} boot_mode_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic wr;
		logic broadcast;
	} ext_req_type;

	typedef struct packed {
		logic vec_wr;
		logic msg_wr;
		logic [MSG_W-1:0] msg_idx;
		logic [DATA_W-1:0] data;
	} slave_acc_type;
endpackage

// ---- core/bus_arbiter.sv ----
// Bus arbitration, boot control and slave registers of one processor
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Identity and straps
	input wire logic [bus_arb_pkg::ID_W-1:0] own_id_i,
	input wire logic rotating_priority_select_i,
	input wire logic core_priority_access_i,
	input wire logic eprom_boot_select_i,
	input wire logic link_boot_select_i,
	input wire logic boot_memory_select_i,
	input wire logic group_boot_eprom_i,
	// Control
	input wire logic lock_i,
	input wire logic limit_en_i,
	input wire logic [bus_arb_pkg::LIMIT_W-1:0] limit_cycles_i,
	input wire logic [bus_arb_pkg::WAIT_W-1:0] wait_states_i,
	input wire logic loaded_i,
	input wire logic boot_done_i,
	input wire logic go_i,
	// Request lines, low active
	input wire logic [bus_arb_pkg::NUM_ID-1:0] bus_request_line_n_i,
	output logic bus_request_line_n_o,
	output logic bus_request_line_oe_n_o,
	// Local access requests
	input wire logic core_req_i,
	input wire logic dma_req_i,
	input wire bus_arb_pkg::ext_req_type ext_req_i,
	input wire logic host_bus_request_i,
	input wire logic ext_ack_i,
	output logic host_bus_grant_o,
	output logic access_done_o,
	output logic dma_stall_o,
	// Outbound bus
	output bus_arb_pkg::ext_req_type ext_bus_o,
	output logic ext_bus_valid_o,
	output logic [(1<<bus_arb_pkg::BANK_W)-1:0] bank_select_n_o,
	// Slave side writes from the master
	input wire logic slave_sel_i,
	input wire logic slave_broadcast_i,
	input wire bus_arb_pkg::slave_acc_type slave_acc_i,
	input wire logic [bus_arb_pkg::MSG_W-1:0] msg_rd_idx_i,
	output logic [bus_arb_pkg::DATA_W-1:0] msg_rd_data_o,
	output logic vec_irq_o,
	output logic [bus_arb_pkg::ADDR_W-1:0] vec_addr_o,
	// Status
	output logic [bus_arb_pkg::ID_W-1:0] owner_o,
	output logic is_master_o,
	output logic transition_o,
	output logic run_o,
	output logic [bus_arb_pkg::ADDR_W-1:0] start_addr_o,
	output logic boot_done_o
);
	localparam int N = bus_arb_pkg::NUM_ID;
	localparam int IW = bus_arb_pkg::ID_W;
	localparam int LW = bus_arb_pkg::LIMIT_W;
	localparam int WW = bus_arb_pkg::WAIT_W;
	localparam int BW = bus_arb_pkg::BANK_W;
	localparam int NB = 1 << BW;

	typedef enum {
		BOOT_WAIT,
		BOOT_LOAD,
		BOOT_HOLD,
		BOOT_RUN
	} boot_state_type;

	logic [N-1:0] req;
	logic [IW-1:0] owner_q;
	logic [IW-1:0] owner_d;
	logic [IW-1:0] rot_q;
	logic [IW-1:0] rot_d;
	logic trans_q;
	logic trans_d;
	logic [IW-1:0] winner;
	logic winner_found;
	int scan_idx;
	logic master_req;
	logic own_master;
	logic [LW-1:0] tenure_q;
	logic tenure_hit;
	logic want_bus;
	logic running;
	logic booting;
	bus_arb_pkg::ext_req_type ext_bus_q;
	logic valid_q;
	logic done_q;
	logic acc_end;
	logic [WW-1:0] wait_q;
	logic [NB-1:0] bank_n_q;
	logic [NB-1:0] bank_n_d;
	logic start_acc;
	logic grant_q;
	boot_state_type boot_q;
	bus_arb_pkg::boot_mode_type mode;
	logic eprom_sel;
	logic [bus_arb_pkg::ADDR_W-1:0] start_q;
	logic boot_done_q;
	logic [bus_arb_pkg::DATA_W-1:0] msg_q [bus_arb_pkg::NUM_MSG];
	logic [bus_arb_pkg::DATA_W-1:0] msg_rd_q;
	logic vec_irq_q;
	logic [bus_arb_pkg::ADDR_W-1:0] vec_addr_q;
	logic slave_wr;

	assign req = ~bus_request_line_n_i;
	always_comb begin
		master_req = 1'b0;
		for (int k = 0; k < N; k++) begin
			if (owner_q == IW'(k + bus_arb_pkg::ID_BASE)) begin
				master_req = req[k];
			end
		end
	end

	// Scan from the highest current priority downwards
	always_comb begin
		winner = bus_arb_pkg::NO_ID;
		winner_found = 1'b0;
		scan_idx = 0;
		for (int k = 0; k < N; k++) begin
			if (rotating_priority_select_i) begin
				scan_idx = (int'(rot_q) + bus_arb_pkg::ID_BASE + k) % N;
			end else begin
				scan_idx = k;
			end
			if (!winner_found && req[scan_idx]) begin
				winner_found = 1'b1;
				winner = IW'(scan_idx + bus_arb_pkg::ID_BASE);
			end
		end
	end

	// Mastership moves only while the master's line is released
	always_comb begin
		owner_d = owner_q;
		rot_d = rot_q;
		trans_d = 1'b0;
		if (!trans_q && !master_req && winner_found) begin
			owner_d = winner;
			rot_d = IW'(int'(winner) - bus_arb_pkg::ID_BASE);
			trans_d = 1'b1;
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			owner_q <= bus_arb_pkg::NO_ID;
			rot_q <= IW'(N - bus_arb_pkg::ID_BASE);
			trans_q <= 1'b0;
		end else begin
			owner_q <= owner_d;
			rot_q <= rot_d;
			trans_q <= trans_d;
		end
	end
	assign own_master = (owner_q == own_id_i) && !trans_q;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tenure_q <= '0;
		end else if (!own_master) begin
			tenure_q <= '0;
		end else if (tenure_q != '1) begin
			tenure_q <= tenure_q + LW'(bus_arb_pkg::COUNT_STEP);
		end
	end
	assign tenure_hit = own_master && limit_en_i && (tenure_q >= limit_cycles_i);

	assign eprom_sel = (own_id_i == bus_arb_pkg::FIRST_ID) ? eprom_boot_select_i
		: group_boot_eprom_i;
	always_comb begin
		if (eprom_sel) begin
			mode = bus_arb_pkg::BOOT_EPROM;
		end else if (link_boot_select_i) begin
			mode = bus_arb_pkg::BOOT_LINK;
		end else if (boot_memory_select_i) begin
			mode = bus_arb_pkg::BOOT_HOST;
		end else begin
			mode = bus_arb_pkg::BOOT_NONE;
		end
	end

	// Host and link boot wait for the loader, eprom boot fetches over the bus
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_q <= BOOT_WAIT;
		end else begin
			unique case (boot_q)
				BOOT_WAIT: begin
					if (mode == bus_arb_pkg::BOOT_NONE) begin
						boot_q <= BOOT_RUN;
					end else if (mode == bus_arb_pkg::BOOT_EPROM) begin
						boot_q <= BOOT_LOAD;
					end else if (loaded_i) begin
						boot_q <= BOOT_RUN;
					end
				end
				BOOT_LOAD: begin
					if (boot_done_i) begin
						boot_q <= BOOT_HOLD;
					end
				end
				BOOT_HOLD: begin
					if (go_i) begin
						boot_q <= BOOT_RUN;
					end
				end
				BOOT_RUN: boot_q <= BOOT_RUN;
			endcase
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_done_q <= 1'b0;
		end else if (boot_q == BOOT_LOAD && boot_done_i) begin
			boot_done_q <= 1'b1;
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			start_q <= bus_arb_pkg::NO_BOOT_ADDR;
		end else if (mode == bus_arb_pkg::BOOT_NONE) begin
			start_q <= bus_arb_pkg::NO_BOOT_ADDR;
		end else begin
			start_q <= bus_arb_pkg::BOOT_LOAD_ADDR;
		end
	end

	assign running = (boot_q == BOOT_RUN);
	assign booting = (boot_q == BOOT_LOAD);
	// A locked master holds its line whatever else happens
	assign want_bus = (own_master && lock_i)
		|| (!host_bus_request_i && !tenure_hit
		&& (booting || (running && (core_req_i || dma_req_i))));
	assign bus_request_line_n_o = !want_bus;
	assign bus_request_line_oe_n_o = !(running || booting);
	assign dma_stall_o = core_priority_access_i && core_req_i && dma_req_i;

	assign start_acc = own_master && !valid_q && (core_req_i || dma_req_i || booting);
	assign acc_end = valid_q && (wait_q == '0) && ext_ack_i;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_bus_q <= '0;
			valid_q <= 1'b0;
			wait_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= acc_end;
			if (start_acc) begin
				ext_bus_q <= ext_req_i;
				valid_q <= 1'b1;
				wait_q <= wait_states_i;
			end else if (valid_q && wait_q != '0) begin
				wait_q <= wait_q - WW'(bus_arb_pkg::COUNT_STEP);
			end else if (acc_end) begin
				valid_q <= 1'b0;
			end
		end
	end

	always_comb begin
		for (int k = 0; k < NB; k++) begin
			bank_n_d[k] = (ext_req_i.addr[bus_arb_pkg::BANK_LSB +: BW] != BW'(k));
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bank_n_q <= '1;
		end else if (start_acc && ext_req_i.addr >= bus_arb_pkg::EXT_BASE) begin
			bank_n_q <= bank_n_d;
		end else if (start_acc || acc_end) begin
			bank_n_q <= '1;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			grant_q <= 1'b0;
		end else begin
			grant_q <= host_bus_request_i && !(own_master && lock_i) && (own_master
				|| (owner_q == bus_arb_pkg::NO_ID && own_id_i == bus_arb_pkg::FIRST_ID));
		end
	end

	assign slave_wr = slave_sel_i || slave_broadcast_i;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int k = 0; k < bus_arb_pkg::NUM_MSG; k++) begin
				msg_q[k] <= '0;
			end
		end else if (slave_wr && slave_acc_i.msg_wr) begin
			msg_q[slave_acc_i.msg_idx] <= slave_acc_i.data;
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			msg_rd_q <= '0;
		end else begin
			msg_rd_q <= msg_q[msg_rd_idx_i];
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vec_irq_q <= 1'b0;
			vec_addr_q <= '0;
		end else begin
			vec_irq_q <= slave_wr && slave_acc_i.vec_wr;
			if (slave_wr && slave_acc_i.vec_wr) begin
				vec_addr_q <= slave_acc_i.data;
			end
		end
	end

	assign owner_o = owner_q;
	assign is_master_o = own_master;
	assign transition_o = trans_q;
	assign run_o = running;
	assign start_addr_o = start_q;
	assign boot_done_o = boot_done_q;
	assign host_bus_grant_o = grant_q;
	assign access_done_o = done_q;
	assign ext_bus_o = ext_bus_q;
	assign ext_bus_valid_o = valid_q;
	assign bank_select_n_o = bank_n_q;
	assign msg_rd_data_o = msg_rd_q;
	assign vec_irq_o = vec_irq_q;
	assign vec_addr_o = vec_addr_q;
endmodule
`default_nettype wire

// ---- tb/bus_arbiter_chk.sv ----
// Assertions on the ports of the bus arbiter
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter_chk (
	input wire logic core_clk_i, reset_n_i, lock_i, loaded_i, core_req_i, dma_req_i,
	input wire logic core_priority_access_i, slave_sel_i, eprom_boot_select_i,
	input wire logic link_boot_select_i, boot_memory_select_i, bus_request_line_n_o,
	input wire logic dma_stall_o, vec_irq_o, is_master_o, transition_o, run_o,
	input wire logic [5:0] bus_request_line_n_i,
	input wire logic [31:0] vec_addr_o, start_addr_o,
	input wire bus_arb_pkg::slave_acc_type slave_acc_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	keep_master_a: assert property (is_master_o && !bus_request_line_n_o |=> is_master_o)
		else $error("master lost bus");
	lock_hold_a: assert property (is_master_o && lock_i |=> is_master_o)
		else $error("locked master lost bus");
	idle_no_turn_a: assert property (&bus_request_line_n_i |=> !transition_o)
		else $error("transition without request");
	one_cycle_a: assert property (transition_o |=> !transition_o)
		else $error("changeover too long");
	host_idle_a: assert property (!eprom_boot_select_i && !link_boot_select_i
		&& boot_memory_select_i && !run_o |-> bus_request_line_n_o) else $error("request");
	no_boot_a: assert property (!eprom_boot_select_i && !link_boot_select_i
		&& !boot_memory_select_i |-> start_addr_o == bus_arb_pkg::NO_BOOT_ADDR) else $error("addr");
	vec_irq_a: assert property (slave_sel_i && slave_acc_i.vec_wr |=> vec_irq_o
		&& vec_addr_o == $past(slave_acc_i.data)) else $error("vector irq");
	cpa_stall_a: assert property (core_priority_access_i && core_req_i && dma_req_i
		|-> ##[0:1] dma_stall_o) else $error("dma not stalled");
	cover property (transition_o);
	cover property (vec_irq_o);
	cover property (dma_stall_o);
endmodule
bind bus_arbiter bus_arbiter_chk chk (.*);
`default_nettype wire

// ---- tb/bus_arbiter_tb.sv ----
// Testbench of the bus arbiter
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter_tb;
	logic core_clk_i=0, reset_n_i=0, rotating_priority_select_i=0, core_priority_access_i=0;
	logic eprom_boot_select_i=0, link_boot_select_i=0, boot_memory_select_i=0, lock_i=0;
	logic group_boot_eprom_i=0, limit_en_i=0, loaded_i=0, boot_done_i=0, go_i=0, core_req_i=0;
	logic dma_req_i=0, host_bus_request_i=0, ext_ack_i=0, slave_sel_i=0, slave_broadcast_i=0;
	logic bus_request_line_n_o, bus_request_line_oe_n_o, host_bus_grant_o, access_done_o;
	logic dma_stall_o, ext_bus_valid_o, vec_irq_o, is_master_o, transition_o, run_o, boot_done_o;
	logic [2:0] own_id_i=3'h1, msg_rd_idx_i=3'h0, owner_o;
	logic [7:0] limit_cycles_i=8'h04;
	logic [3:0] wait_states_i=4'h1, bank_select_n_o;
	logic [5:0] want=6'h00;
	wire logic [5:0] bus_request_line_n_i;
	logic [31:0] msg_rd_data_o, vec_addr_o, start_addr_o, d, mdl[8];
	bus_arb_pkg::ext_req_type ext_req_i='0, ext_bus_o;
	bus_arb_pkg::slave_acc_type slave_acc_i='0;
	integer seed=82131, err_total=0, n_tests=0, i;
	integer m_owner=0, m_rot=5, m_trans=0, k, idx, hit;
	logic [5:0] l;
	bus_arbiter dut (.*);
	far_procs peer (.core_clk_i, .want_i(want), .own_n_i(bus_request_line_n_o),
		.oe_n_i(bus_request_line_oe_n_o), .lines_n_o(bus_request_line_n_i));
	initial forever #25 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i or negedge reset_n_i) begin
		l = ~bus_request_line_n_i;
		if (!reset_n_i) begin
			m_owner = 0;
			m_rot = 5;
			m_trans = 0;
		end else if (m_trans) begin
			m_trans = 0;
		end else if ((m_owner == 0 || !l[m_owner-1]) && l != 0) begin
			hit = 0;
			for (k = 1; k <= 6; k++) begin
				idx = rotating_priority_select_i ? (m_rot + k) % 6 : k - 1;
				if (!hit && l[idx]) begin
					hit = 1;
					m_owner = idx + 1;
					m_rot = idx;
				end
			end
			m_trans = 1;
		end
	end
	task give_verdict; begin
		$display("mismatches %0d comparisons %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	end endtask
	task chk(input logic [31:0] got, input logic [31:0] exp); begin
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end endtask
	initial begin
		#100000 err_total++;
		give_verdict;
	end
	initial begin
		repeat (10) @(negedge core_clk_i);
		reset_n_i = 1;
		repeat (4) @(negedge core_clk_i);
		chk(start_addr_o, bus_arb_pkg::NO_BOOT_ADDR);
		for (i = 0; i < 16; i++) begin
			d = $random(seed);
			slave_sel_i = 1;
			slave_acc_i = {i[3], !i[3], i[2:0], d};
			if (!i[3]) mdl[i & 7] = d;
			@(negedge core_clk_i) slave_sel_i = 0;
			msg_rd_idx_i = i[2:0];
			@(negedge core_clk_i) chk(msg_rd_data_o, mdl[i & 7]);
			if (i[3]) chk(vec_addr_o, d);
		end
		boot_memory_select_i = 1; // Host boot straps
		core_req_i = 1;
		reset_n_i = 0;
		repeat (2) @(negedge core_clk_i);
		reset_n_i = 1;
		repeat (3) @(negedge core_clk_i) begin
			chk(run_o, 0);
			chk(bus_request_line_n_o, 1);
		end
		loaded_i = 1;
		repeat (2) @(negedge core_clk_i);
		chk(run_o, 1);
		repeat (400) @(negedge core_clk_i) begin
			chk(owner_o, m_owner);
			chk(transition_o, m_trans);
			{lock_i, core_req_i, dma_req_i, core_priority_access_i,
				rotating_priority_select_i, loaded_i, limit_en_i, ext_ack_i, host_bus_request_i,
				go_i, boot_done_i, slave_broadcast_i, want} = 18'($random(seed));
		end
		give_verdict;
	end
endmodule
`default_nettype wire

// ---- tb/far_procs.sv ----
// Model of the other processors on the request lines
`timescale 1ns/1ps
`default_nettype none
module far_procs (
	input wire logic core_clk_i,
	input wire logic [5:0] want_i,
	input wire logic own_n_i,
	input wire logic oe_n_i,
	output logic [5:0] lines_n_o
);
	logic [4:0] peer_q;
	always_ff @(posedge core_clk_i) peer_q <= ~want_i[5:1]; // Each peer drives its own line
	assign lines_n_o = {peer_q, own_n_i | oe_n_i}; // Released own line pulled high
endmodule
`default_nettype wire
